// file: include/tws_defs.svh
// constants shared by both ends of the two-wire word link
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
`define TWS_CLK_HZ 100000000
`define TWS_FS_HZ 400000
`define TWS_HS_HZ 3400000
`define TWS_TIMEOUT_MS 28
`define TWS_TIMEOUT_CYC (`TWS_TIMEOUT_MS * (`TWS_CLK_HZ / 1000))
`define TWS_FS_QTR ((`TWS_CLK_HZ + 4 * `TWS_FS_HZ - 1) / (4 * `TWS_FS_HZ))
`define TWS_HS_QTR ((`TWS_CLK_HZ + 4 * `TWS_HS_HZ - 1) / (4 * `TWS_HS_HZ))
`define TWS_ADDR_HI 5'h10
`define TWS_HS_CODE 5'h01
`define TWS_HS_LOW 3'h0
`define TWS_FS_FILT 3'h4
`define TWS_HS_FILT 3'h1
`define TWS_LAST_BIT 4'h7
`define TWS_ACK_BIT 4'h8
`define TWS_ACK_DONE 4'h9
`endif

// file: include/tws_pkg.sv
// state types of the two-wire word link
package tws_pkg;
   typedef enum logic [2:0] {
      TWS_S_IDLE, TWS_S_ADDR, TWS_S_WRITE, TWS_S_READ, TWS_S_IGNORE
   } tws_sst_t;
   typedef enum logic [2:0] {
      TWS_M_IDLE, TWS_M_START, TWS_M_BYTE, TWS_M_STOP, TWS_M_HOLD
   } tws_mst_t;
   typedef enum logic [1:0] {
      TWS_K_CODE, TWS_K_ADDR, TWS_K_HI, TWS_K_LO
   } tws_kind_t;
endpackage : tws_pkg

// file: include/tws_if.sv
// open-drain two-wire bus joining master end and slave end
`timescale 1ns/1ps
`default_nettype none
interface tws_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic scl;
   logic sda;
   // wired-and with pull-ups: a line is low while any enabled driver is low
   assign scl = ~(m_scl_oe & ~m_scl_o);
   assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
   modport host (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
                 input scl, sda);
   modport dev (output s_sda_o, s_sda_oe, input scl, sda);
endinterface : tws_if
`default_nettype wire

// file: rtl/tws_slave.sv
// slave end of the two-wire word link with its receive fifo
`timescale 1ns/1ps
`default_nettype none
`include "tws_defs.svh"

module tws_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
   logic [AW:0] cnt_ff, nxt_cnt;
   logic push, pop;

   assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_ff != '0);
   assign out_data_o = mem_ff[rp_ff];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_comb begin
      nxt_wp = wp_ff;
      nxt_rp = rp_ff;
      nxt_cnt = cnt_ff;
      if (push) begin
         nxt_wp = (wp_ff == AW'(DEPTH - 1)) ? '0 : AW'(wp_ff + 1'b1);
      end
      if (pop) begin
         nxt_rp = (rp_ff == AW'(DEPTH - 1)) ? '0 : AW'(rp_ff + 1'b1);
      end
      if (push && !pop) begin
         nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
      end else if (pop && !push) begin
         nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_ff <= nxt_cnt;
      end
      if (push) begin
         mem_ff[wp_ff] <= in_data_i;
      end
   end
endmodule : tws_fifo

// Summary of operation
// - upper byte first, lower byte second
// - own address derived from strap pin
// - ack or nack after last byte
// - master code start plus 00001xxx byte
// - master code sent at fast speed
// - master code unacknowledged, switches to high-speed filter
// - repeated start then normal protocol, faster
// - repeated starts keep high-speed mode
// - stop ends high-speed mode
// - idle bus never driven
// - strap picks one of four, per transaction
// - write: address, two acked data bytes
// - read: upper byte, master ack, lower
// - timeout abandons transaction, releases bus
module tws_slave #(
   parameter int unsigned TIMEOUT_CYC = `TWS_TIMEOUT_CYC,
   parameter int unsigned FIFO_DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic srst_i,
   tws_if.dev bus,
   input wire logic [1:0] address_strap_pin_i,
   input wire logic [15:0] rd_word_i,
   output logic [15:0] wr_word_o,
   output logic wr_valid_o,
   input wire logic wr_ready_i,
   output logic hs_mode_o
);
   logic [1:0] s1_ff, s2_ff, s3_ff, filt_ff, prv_ff;
   logic [1:0] nxt_filt;
   logic [2:0] fcnt_ff [2];
   logic [2:0] nxt_fcnt [2];
   logic [1:0] strap1_ff, strap2_ff, strap3_ff, strap_ff;
   logic [2:0] flim;
   logic scl_rise, scl_fall, start_c, stop_c;
   tws_pkg::tws_sst_t st_ff, nxt_st;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [7:0] sh_ff, nxt_sh, tx_ff, nxt_tx, lo_ff, nxt_lo, hi_ff, nxt_hi;
   logic [6:0] adr_ff, nxt_adr;
   logic oe_ff, nxt_oe, rw_ff, nxt_rw, idx_ff, nxt_idx;
   logic hs_ff, nxt_hs, nak_ff, nxt_nak, push, fifo_rdy;
   logic [31:0] to_ff, nxt_to;

   // index 1 is the clock line, index 0 the data line
   assign flim = hs_ff ? `TWS_HS_FILT : `TWS_FS_FILT;
   generate
      for (genvar g = 0; g < 2; g++) begin : g_filt
         always_comb begin
            nxt_filt[g] = filt_ff[g];
            nxt_fcnt[g] = '0;
            if (s2_ff[g] == s3_ff[g] && s2_ff[g] != filt_ff[g]) begin
               if (3'(fcnt_ff[g] + 3'h1) >= flim) begin
                  nxt_filt[g] = s3_ff[g];
               end else begin
                  nxt_fcnt[g] = 3'(fcnt_ff[g] + 3'h1);
               end
            end
         end
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               filt_ff[g] <= 1'b1;
               fcnt_ff[g] <= '0;
            end else begin
               filt_ff[g] <= nxt_filt[g];
               fcnt_ff[g] <= nxt_fcnt[g];
            end
         end
      end
   endgenerate

   assign scl_rise = filt_ff[1] & ~prv_ff[1];
   assign scl_fall = ~filt_ff[1] & prv_ff[1];
   assign start_c = filt_ff[1] & prv_ff[1] & prv_ff[0] & ~filt_ff[0];
   assign stop_c = filt_ff[1] & prv_ff[1] & ~prv_ff[0] & filt_ff[0];

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_sh = sh_ff;
      nxt_tx = tx_ff;
      nxt_lo = lo_ff;
      nxt_hi = hi_ff;
      nxt_adr = adr_ff;
      nxt_oe = oe_ff;
      nxt_rw = rw_ff;
      nxt_idx = idx_ff;
      nxt_hs = hs_ff;
      nxt_nak = nak_ff;
      push = 1'b0;
      nxt_to = (st_ff == tws_pkg::TWS_S_IDLE) ? '0 : 32'(to_ff + 32'h1);
      if (stop_c) begin
         nxt_st = tws_pkg::TWS_S_IDLE;
         nxt_oe = 1'b0;
         nxt_hs = 1'b0;
      end else if (start_c) begin
         // repeated start keeps high-speed mode
         nxt_st = tws_pkg::TWS_S_ADDR;
         nxt_cnt = '0;
         nxt_oe = 1'b0;
         nxt_to = '0;
         nxt_adr = {`TWS_ADDR_HI, strap_ff};
      end else if (st_ff != tws_pkg::TWS_S_IDLE &&
                   to_ff >= 32'(TIMEOUT_CYC - 1)) begin
         nxt_st = tws_pkg::TWS_S_IDLE;
         nxt_oe = 1'b0;
         nxt_hs = 1'b0;
      end else if (scl_rise) begin
         if (cnt_ff < `TWS_ACK_DONE) begin
            nxt_cnt = 4'(cnt_ff + 4'h1);
         end
         if (cnt_ff <= `TWS_LAST_BIT) begin
            nxt_sh = {sh_ff[6:0], filt_ff[0]};
         end else if (cnt_ff == `TWS_ACK_BIT) begin
            nxt_nak = filt_ff[0];
         end
      end else if (scl_fall) begin
         case (st_ff)
            tws_pkg::TWS_S_ADDR: begin
               if (cnt_ff == `TWS_ACK_BIT) begin
                  if (sh_ff[7:1] == adr_ff) begin
                     nxt_oe = 1'b1;
                     nxt_rw = sh_ff[0];
                  end else begin
                     // no ack for master code or foreign address
                     nxt_st = tws_pkg::TWS_S_IGNORE;
                     if (sh_ff[7:3] == `TWS_HS_CODE) begin
                        nxt_hs = 1'b1;
                     end
                  end
               end else if (cnt_ff == `TWS_ACK_DONE) begin
                  nxt_cnt = '0;
                  nxt_idx = 1'b0;
                  nxt_oe = 1'b0;
                  nxt_st = tws_pkg::TWS_S_WRITE;
                  if (rw_ff) begin
                     nxt_st = tws_pkg::TWS_S_READ;
                     nxt_tx = rd_word_i[15:8];
                     nxt_lo = rd_word_i[7:0];
                     nxt_oe = ~rd_word_i[15];
                  end
               end
            end
            tws_pkg::TWS_S_WRITE: begin
               if (cnt_ff == `TWS_ACK_BIT) begin
                  if (!idx_ff) begin
                     nxt_hi = sh_ff;
                     nxt_oe = 1'b1;
                  end else if (fifo_rdy) begin
                     push = 1'b1;
                     nxt_oe = 1'b1;
                  end else begin
                     // full fifo: low byte refused, word dropped
                     nxt_st = tws_pkg::TWS_S_IGNORE;
                  end
               end else if (cnt_ff == `TWS_ACK_DONE) begin
                  nxt_cnt = '0;
                  nxt_oe = 1'b0;
                  nxt_idx = ~idx_ff;
               end
            end
            tws_pkg::TWS_S_READ: begin
               if (cnt_ff == `TWS_ACK_BIT) begin
                  nxt_oe = 1'b0;
               end else if (cnt_ff == `TWS_ACK_DONE) begin
                  nxt_cnt = '0;
                  nxt_oe = 1'b0;
                  // an ack after the low byte is harmless: bus released
                  nxt_st = tws_pkg::TWS_S_IGNORE;
                  if (!nak_ff && !idx_ff) begin
                     nxt_st = tws_pkg::TWS_S_READ;
                     nxt_idx = 1'b1;
                     nxt_tx = lo_ff;
                     nxt_oe = ~lo_ff[7];
                  end
               end else if (cnt_ff != 4'h0) begin
                  nxt_tx = {tx_ff[6:0], 1'b0};
                  nxt_oe = ~tx_ff[6];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      s1_ff <= {bus.scl, bus.sda};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      strap1_ff <= address_strap_pin_i;
      strap2_ff <= strap1_ff;
      strap3_ff <= strap2_ff;
      // strap level only taken once two stages agree
      if (strap2_ff == strap3_ff) begin
         strap_ff <= strap3_ff;
      end
      if (srst_i) begin
         prv_ff <= 2'h3;
         st_ff <= tws_pkg::TWS_S_IDLE;
         cnt_ff <= '0;
         sh_ff <= '0;
         tx_ff <= '0;
         lo_ff <= '0;
         hi_ff <= '0;
         adr_ff <= '0;
         oe_ff <= 1'b0;
         rw_ff <= 1'b0;
         idx_ff <= 1'b0;
         hs_ff <= 1'b0;
         nak_ff <= 1'b0;
         to_ff <= '0;
      end else begin
         prv_ff <= filt_ff;
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         sh_ff <= nxt_sh;
         tx_ff <= nxt_tx;
         lo_ff <= nxt_lo;
         hi_ff <= nxt_hi;
         adr_ff <= nxt_adr;
         oe_ff <= nxt_oe;
         rw_ff <= nxt_rw;
         idx_ff <= nxt_idx;
         hs_ff <= nxt_hs;
         nak_ff <= nxt_nak;
         to_ff <= nxt_to;
      end
   end

   // open drain: the pin only ever pulls low
   assign bus.s_sda_o = 1'b0;
   assign bus.s_sda_oe = oe_ff;
   assign hs_mode_o = hs_ff;

   tws_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .in_valid_i(push),
      .in_ready_o(fifo_rdy),
      .in_data_i({hi_ff, sh_ff}),
      .out_valid_o(wr_valid_o),
      .out_ready_i(wr_ready_i),
      .out_data_o(wr_word_o)
   );
endmodule : tws_slave
`default_nettype wire

// file: rtl/tws_master.sv
// master end of the two-wire word link
`timescale 1ns/1ps
`default_nettype none
`include "tws_defs.svh"

module tws_master #(
   parameter int unsigned FS_QTR = `TWS_FS_QTR,
   parameter int unsigned HS_QTR = `TWS_HS_QTR
) (
   input wire logic clk_i,
   input wire logic srst_i,
   tws_if.host bus,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic cmd_write_i,
   input wire logic cmd_hs_i,
   input wire logic cmd_keep_i,
   input wire logic [6:0] cmd_addr_i,
   input wire logic [15:0] cmd_wdata_i,
   output logic rsp_valid_o,
   output logic rsp_nack_o,
   output logic [15:0] rsp_rdata_o,
   output logic hs_mode_o
);
   tws_pkg::tws_mst_t st_ff, nxt_st;
   tws_pkg::tws_kind_t kind_ff, nxt_kind;
   logic [2:0] sda_s_ff;
   logic sda_f_ff, nxt_sda_f;
   logic [7:0] div_ff, nxt_div, qtr;
   logic [1:0] ph_ff, nxt_ph;
   logic [3:0] bit_ff, nxt_bit;
   logic [7:0] tx_ff, nxt_tx;
   logic [15:0] rx_ff, nxt_rx, wd_ff, nxt_wd;
   logic [6:0] adr_ff, nxt_adr;
   logic wr_ff, nxt_wr, keep_ff, nxt_keep, hs_ff, nxt_hs;
   logic scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
   logic rdy_ff, nxt_rdy, rv_ff, nxt_rv, nak_ff, nxt_nak, ack_ff, nxt_ack;
   logic tick, sending, idle;

   // fast-mode quarter period until the master code has gone out
   assign qtr = hs_ff ? 8'(HS_QTR - 1) : 8'(FS_QTR - 1);
   assign tick = (div_ff == qtr);
   assign idle = (st_ff == tws_pkg::TWS_M_IDLE) ||
                 (st_ff == tws_pkg::TWS_M_HOLD);
   assign sending = wr_ff || (kind_ff == tws_pkg::TWS_K_CODE) ||
                    (kind_ff == tws_pkg::TWS_K_ADDR);

   always_comb begin
      nxt_st = st_ff;
      nxt_kind = kind_ff;
      nxt_sda_f = (sda_s_ff[1] == sda_s_ff[2]) ? sda_s_ff[2] : sda_f_ff;
      nxt_div = (idle || tick) ? '0 : 8'(div_ff + 8'h1);
      nxt_ph = ph_ff;
      nxt_bit = bit_ff;
      nxt_tx = tx_ff;
      nxt_rx = rx_ff;
      nxt_wd = wd_ff;
      nxt_adr = adr_ff;
      nxt_wr = wr_ff;
      nxt_keep = keep_ff;
      nxt_hs = hs_ff;
      nxt_scl_oe = scl_oe_ff;
      nxt_sda_oe = sda_oe_ff;
      nxt_rv = 1'b0;
      nxt_nak = nak_ff;
      nxt_ack = ack_ff;
      if (idle) begin
         if (cmd_valid_i && rdy_ff) begin
            nxt_st = tws_pkg::TWS_M_START;
            nxt_ph = '0;
            nxt_wr = cmd_write_i;
            nxt_keep = cmd_keep_i;
            nxt_adr = cmd_addr_i;
            nxt_wd = cmd_wdata_i;
            nxt_nak = 1'b0;
            // within a kept high-speed run no new master code
            nxt_kind = (cmd_hs_i && !hs_ff) ? tws_pkg::TWS_K_CODE :
                       tws_pkg::TWS_K_ADDR;
         end
      end else if (tick) begin
         nxt_ph = 2'(ph_ff + 2'h1);
         case (st_ff)
            tws_pkg::TWS_M_START: begin
               case (ph_ff)
                  2'h0: nxt_sda_oe = 1'b0;
                  2'h1: nxt_scl_oe = 1'b0;
                  2'h2: nxt_sda_oe = 1'b1;
                  default: begin
                     nxt_scl_oe = 1'b1;
                     nxt_st = tws_pkg::TWS_M_BYTE;
                     nxt_bit = '0;
                     case (kind_ff)
                        tws_pkg::TWS_K_CODE: nxt_tx = {`TWS_HS_CODE,
                                                       `TWS_HS_LOW};
                        default: nxt_tx = {adr_ff, ~wr_ff};
                     endcase
                  end
               endcase
            end
            tws_pkg::TWS_M_BYTE: begin
               case (ph_ff)
                  2'h0: begin
                     if (bit_ff <= `TWS_LAST_BIT) begin
                        nxt_sda_oe = sending & ~tx_ff[7];
                     end else begin
                        // ack the high byte, nack the low one
                        nxt_sda_oe = ~sending &&
                                     (kind_ff == tws_pkg::TWS_K_HI);
                     end
                  end
                  2'h1: nxt_scl_oe = 1'b0;
                  2'h2: begin
                     if (bit_ff <= `TWS_LAST_BIT) begin
                        nxt_tx = {tx_ff[6:0], 1'b0};
                        if (!sending) begin
                           nxt_rx = {rx_ff[14:0], sda_f_ff};
                        end
                     end else begin
                        nxt_ack = ~sda_f_ff;
                     end
                  end
                  default: begin
                     nxt_scl_oe = 1'b1;
                     nxt_bit = 4'(bit_ff + 4'h1);
                     if (bit_ff == `TWS_ACK_BIT) begin
                        nxt_bit = '0;
                        nxt_sda_oe = 1'b0;
                        case (kind_ff)
                           tws_pkg::TWS_K_CODE: begin
                              nxt_hs = 1'b1;
                              nxt_kind = tws_pkg::TWS_K_ADDR;
                              nxt_st = tws_pkg::TWS_M_START;
                           end
                           tws_pkg::TWS_K_ADDR: begin
                              nxt_kind = tws_pkg::TWS_K_HI;
                              nxt_tx = wd_ff[15:8];
                              if (!ack_ff) begin
                                 nxt_nak = 1'b1;
                                 nxt_st = tws_pkg::TWS_M_STOP;
                              end
                           end
                           tws_pkg::TWS_K_HI: begin
                              nxt_kind = tws_pkg::TWS_K_LO;
                              nxt_tx = wd_ff[7:0];
                              if (wr_ff && !ack_ff) begin
                                 nxt_nak = 1'b1;
                                 nxt_st = tws_pkg::TWS_M_STOP;
                              end
                           end
                           default: begin
                              nxt_nak = wr_ff & ~ack_ff;
                              nxt_st = tws_pkg::TWS_M_STOP;
                              if (keep_ff) begin
                                 nxt_st = tws_pkg::TWS_M_HOLD;
                                 nxt_rv = 1'b1;
                              end
                           end
                        endcase
                     end
                  end
               endcase
            end
            tws_pkg::TWS_M_STOP: begin
               case (ph_ff)
                  2'h0: nxt_sda_oe = 1'b1;
                  2'h1: nxt_scl_oe = 1'b0;
                  2'h2: nxt_sda_oe = 1'b0;
                  default: begin
                     nxt_st = tws_pkg::TWS_M_IDLE;
                     nxt_hs = 1'b0;
                     nxt_rv = 1'b1;
                  end
               endcase
            end
            default: begin
            end
         endcase
      end
      nxt_rdy = ((nxt_st == tws_pkg::TWS_M_IDLE) ||
                 (nxt_st == tws_pkg::TWS_M_HOLD)) && !nxt_rv;
   end

   always_ff @(posedge clk_i) begin
      sda_s_ff <= {sda_s_ff[1:0], bus.sda};
      if (srst_i) begin
         st_ff <= tws_pkg::TWS_M_IDLE;
         kind_ff <= tws_pkg::TWS_K_ADDR;
         sda_f_ff <= 1'b1;
         div_ff <= '0;
         ph_ff <= '0;
         bit_ff <= '0;
         tx_ff <= '0;
         rx_ff <= '0;
         wd_ff <= '0;
         adr_ff <= '0;
         wr_ff <= 1'b0;
         keep_ff <= 1'b0;
         hs_ff <= 1'b0;
         scl_oe_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         rdy_ff <= 1'b0;
         rv_ff <= 1'b0;
         nak_ff <= 1'b0;
         ack_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         kind_ff <= nxt_kind;
         sda_f_ff <= nxt_sda_f;
         div_ff <= nxt_div;
         ph_ff <= nxt_ph;
         bit_ff <= nxt_bit;
         tx_ff <= nxt_tx;
         rx_ff <= nxt_rx;
         wd_ff <= nxt_wd;
         adr_ff <= nxt_adr;
         wr_ff <= nxt_wr;
         keep_ff <= nxt_keep;
         hs_ff <= nxt_hs;
         scl_oe_ff <= nxt_scl_oe;
         sda_oe_ff <= nxt_sda_oe;
         rdy_ff <= nxt_rdy;
         rv_ff <= nxt_rv;
         nak_ff <= nxt_nak;
         ack_ff <= nxt_ack;
      end
   end

   assign bus.m_scl_o = 1'b0;
   assign bus.m_scl_oe = scl_oe_ff;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_sda_oe = sda_oe_ff;
   assign cmd_ready_o = rdy_ff;
   assign rsp_valid_o = rv_ff;
   assign rsp_nack_o = nak_ff;
   assign rsp_rdata_o = rx_ff;
   assign hs_mode_o = hs_ff;
endmodule : tws_master
`default_nettype wire

// file: sim/tws_properties.sv
// assertions on the shared two-wire bus
`timescale 1ns/1ps
`default_nettype none
module tws_properties #(
   parameter int unsigned TIMEOUT_CYC = 20000
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic m_scl_oe_i,
   input wire logic m_sda_oe_i,
   input wire logic s_sda_oe_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic hs_mode_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // length of one unbroken slave pull, must never reach the timeout
   logic [31:0] drv_cnt_ff;
   logic [31:0] nxt_drv_cnt;
   always_comb begin
      nxt_drv_cnt = drv_cnt_ff + 32'h0000_0001;
      if (srst_i || !s_sda_oe_i) begin
         nxt_drv_cnt = 32'h0000_0000;
      end
   end
   always_ff @(posedge clk_i) begin
      drv_cnt_ff <= nxt_drv_cnt;
   end
   chk_reset_quiet: assert property (disable iff (1'b0)
      srst_i |=> !s_sda_oe_i && !m_scl_oe_i && !m_sda_oe_i)
      else $error("bus driven during reset");
   chk_hs_reset: assert property (disable iff (1'b0)
      srst_i |=> !hs_mode_i)
      else $error("fast mode survives reset");
   chk_data_hold: assert property (
      scl_i && $past(scl_i) |-> $stable(s_sda_oe_i))
      else $error("slave moved data while clock high");
   chk_stop_ends_hs: assert property (
      $rose(sda_i) && scl_i |-> ##[1:16] !hs_mode_i)
      else $error("stop left fast mode on");
   chk_stop_idle: assert property (
      $rose(sda_i) && scl_i |=> !s_sda_oe_i [*4])
      else $error("slave drives idle bus");
   chk_addr_quiet: assert property (
      $fell(sda_i) && scl_i |-> !s_sda_oe_i [*8])
      else $error("slave drives during address");
   chk_code_noack: assert property (
      $rose(hs_mode_i) |-> !s_sda_oe_i [*8])
      else $error("master code acknowledged");
   chk_drive_bound: assert property (
      drv_cnt_ff < TIMEOUT_CYC)
      else $error("slave held data line too long");
endmodule : tws_properties
`default_nettype wire

// file: sim/two_wire_slave_word_access_hs_tb_top.sv
// self-checking bench joining both ends of the two-wire word link
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_word_access_hs_tb_top;
   localparam int unsigned TMO = 20000;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [1:0] strap = 2'h0;
   logic [15:0] rd_word = 16'h0000;
   logic wr_ready = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic cmd_hs = 1'b0;
   logic cmd_keep = 1'b0;
   logic [6:0] cmd_addr = 7'h00;
   logic [15:0] cmd_wdata = 16'h0000;
   logic cmd_ready, rsp_valid, rsp_nack, m_hs, s_hs, wr_valid, r_nack;
   logic [15:0] rsp_rdata, wr_word, r_data;
   int num_errors = 0;
   int comparisons = 0;
   tws_if bus ();
   tws_master #(.FS_QTR(20), .HS_QTR(8)) u_tws_master (.clk_i(clk_i),
      .srst_i(srst_i), .bus(bus.host), .cmd_valid_i(cmd_valid),
      .cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write), .cmd_hs_i(cmd_hs),
      .cmd_keep_i(cmd_keep), .cmd_addr_i(cmd_addr),
      .cmd_wdata_i(cmd_wdata), .rsp_valid_o(rsp_valid),
      .rsp_nack_o(rsp_nack), .rsp_rdata_o(rsp_rdata), .hs_mode_o(m_hs));
   tws_slave #(.TIMEOUT_CYC(TMO), .FIFO_DEPTH(8)) u_tws_slave (
      .clk_i(clk_i), .srst_i(srst_i), .bus(bus.dev),
      .address_strap_pin_i(strap), .rd_word_i(rd_word),
      .wr_word_o(wr_word), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
      .hs_mode_o(s_hs));
   tws_properties #(.TIMEOUT_CYC(TMO)) u_tws_properties (.clk_i(clk_i),
      .srst_i(srst_i), .m_scl_oe_i(bus.m_scl_oe),
      .m_sda_oe_i(bus.m_sda_oe), .s_sda_oe_i(bus.s_sda_oe),
      .scl_i(bus.scl), .sda_i(bus.sda), .hs_mode_i(s_hs));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   task automatic final_report();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t word %h expected %h", $time, got, exp);
      end
   endtask : cmp_word
   task automatic cmp_flag(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask : cmp_flag
   // one command, then wait for its response pulse
   task automatic xfer(input logic wr, input logic hs, input logic keep,
                       input logic [6:0] a, input logic [15:0] d);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 9999) begin
         @(posedge clk_i);
         n++;
      end
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_hs <= hs;
      cmd_keep <= keep;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge clk_i);
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp_valid !== 1'b1 && n < 9999);
      cmp_flag(rsp_valid, 1'b1);
      r_nack = rsp_nack;
      r_data = rsp_rdata;
   endtask : xfer
   // skip one edge first so values from the last pop have landed
   task automatic pop(input logic [15:0] exp);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wr_valid !== 1'b1 && n < 99);
      cmp_word(wr_word, exp);
      wr_ready <= 1'b1;
      @(posedge clk_i);
      wr_ready <= 1'b0;
   endtask : pop
   initial begin
      #900000;
      num_errors++;
      final_report();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      for (int c = 0; c < 4; c++) begin
         strap <= c[1:0];
         rd_word <= 16'hc3a0 | c[15:0];
         xfer(1'b1, 1'b0, 1'b0, {5'h10, c[1:0]}, 16'h9e00 | c[15:0]);
         cmp_flag(r_nack, 1'b0);
         pop(16'h9e00 | c[15:0]);
         xfer(1'b1, 1'b0, 1'b0, {5'h10, c[1:0] ^ 2'h1}, 16'h5555);
         cmp_flag(r_nack, 1'b1);
         cmp_flag(wr_valid, 1'b0);
         xfer(1'b0, 1'b0, 1'b0, {5'h10, c[1:0]}, 16'h0000);
         cmp_word(r_data, 16'hc3a0 | c[15:0]);
      end
      for (int i = 0; i < 9; i++) begin
         xfer(1'b1, 1'b0, 1'b0, 7'h43, 16'h7100 | i[15:0]);
         cmp_flag(r_nack, i == 8);
      end
      for (int i = 0; i < 8; i++) begin
         pop(16'h7100 | i[15:0]);
      end
      @(posedge clk_i);
      cmp_flag(wr_valid, 1'b0);
      xfer(1'b1, 1'b1, 1'b1, 7'h43, 16'hb1e4);
      cmp_flag(s_hs, 1'b1);
      cmp_flag(m_hs, 1'b1);
      pop(16'hb1e4);
      xfer(1'b0, 1'b0, 1'b1, 7'h43, 16'h0000);
      cmp_word(r_data, 16'hc3a3);
      cmp_flag(s_hs, 1'b1);
      // master parks with the clock low, so only the timeout frees it
      repeat (TMO + 1000) @(posedge clk_i);
      cmp_flag(s_hs, 1'b0);
      cmp_flag(bus.s_sda_oe, 1'b0);
      xfer(1'b1, 1'b1, 1'b0, 7'h43, 16'h0f0f);
      pop(16'h0f0f);
      xfer(1'b1, 1'b1, 1'b0, 7'h43, 16'h1234);
      cmp_flag(r_nack, 1'b0);
      cmp_flag(s_hs, 1'b0);
      cmp_flag(m_hs, 1'b0);
      pop(16'h1234);
      final_report();
   end
endmodule : two_wire_slave_word_access_hs_tb_top
`default_nettype wire
